/* hdl/clp_consts.svh */
`ifndef CLP_CONSTS_SVH
`define CLP_CONSTS_SVH
// Timing
`define CLP_CLK_NS      10
`define CLP_TICK_NS     5000000
`define CLP_TW          19
// Hysteresis ratio in percent
`define CLP_HYST_PCT    24'h000061
`define CLP_FULL_PCT    24'h000064
`define CLP_HIST_N      4'hC
// Reset values (timers in 5 ms steps, currents in 0.01 x In)
`define CLP_DEF_START   19'h007D0
`define CLP_DEF_INRUSH  19'h01770
`define CLP_DEF_HOLD    19'h00008
`define CLP_DEF_LOW     16'h0014
`define CLP_DEF_HIGH    16'h0078
`define CLP_DEF_OVER    16'h00C8
`define CLP_DEF_MASK    16'hFFFF
// Register byte addresses
`define CLP_A_EVMASK    8'h00
`define CLP_A_LOW       8'h04
`define CLP_A_HIGH      8'h08
`define CLP_A_OVER      8'h0C
`define CLP_A_START     8'h10
`define CLP_A_INRUSH    8'h14
`define CLP_A_HOLD      8'h18
`define CLP_A_STATUS    8'h1C
`define CLP_A_HSEL      8'h20
`define CLP_A_RTIME     8'h24
`define CLP_A_RID       8'h28
`define CLP_A_RI12      8'h2C
`define CLP_A_RI3       8'h30
`define CLP_A_RTTA      8'h34
`define CLP_A_RACT      8'h38
`define CLP_A_RSTART    8'h3C
`define CLP_A_RRECL     8'h40
// Event identities
`define CLP_EV_ACT      3'h4
`define CLP_EV_BLK      3'h5
`endif

/* hdl/clp_pkg.sv */
package clp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_ACT, ST_INR, ST_SET, ST_BLK
  } clp_state_t;
  typedef struct packed {
    logic        valid;
    logic [2:0]  id;
    logic        on;
    logic [31:0] stamp;
  } clp_ev_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0]  id;
    logic [2:0]  group;
    logic [15:0] i1;
    logic [15:0] i2;
    logic [15:0] i3;
    logic [18:0] to_act;
    logic [18:0] act_time;
    logic [18:0] start_time;
    logic [18:0] reclaim;
  } clp_rec_t;
endpackage

/* hdl/clp_timing.sv */
// Summary of operation
// - Activate after all currents low for delay
// - Inrush time bounded by programmable maximum
// - Stay active at least minimum hold time
// - High current while active starts inrush timer
// - Current between thresholds ends start-up
// - Nonzero hold extends activation past start-up
// - Low ending before delay prevents activation
// - Zero delay activates immediately
// - Overcurrent releases activation at once
// - Inrush lasting to maximum releases activation
// - Between thresholds: release after hold time
// - Inrush during hold: keep until timers done
// - ON and OFF events on every flag change
// - Per-event ON/OFF storage selection
// - Events carry time stamp, identity and ON/OFF
// - Twelve-deep rolling record history
// - Record holds time, identity, currents, timers
// - Comparators drop out at 97 percent
// - Block at pick-up gives blocked output
// - Low needs all phases low, high all high
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "clp_consts.svh"
module clp_timing
  import clp_pkg::*;
#(
  parameter int TICK_CYC = `CLP_TICK_NS / `CLP_CLK_NS
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Measurement and control
  input  wire logic [15:0] phase_current [3],
  input  wire logic        block_in,
  input  wire logic [2:0]  setting_group,
  input  wire logic [31:0] time_stamp,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Status outputs
  output logic             cold_load_active,
  output logic             blocked_out,
  output logic             low_start_flag,
  output logic             high_start_flag,
  output logic             load_normal_flag,
  output logic             over_current_flag,
  // Event stream
  output clp_ev_t          event_out
);

  function automatic logic hyst(input logic prev, input logic [15:0] cur,
                                input logic [15:0] thr);
    logic [23:0] c;
    logic [23:0] t;
    c = 24'(cur) * `CLP_FULL_PCT;
    t = 24'(thr) * `CLP_HYST_PCT;
    hyst = prev ? (c >= t) : (cur > thr);
  endfunction

  function automatic logic [18:0] inc_sat(input logic [18:0] v);
    inc_sat = (&v) ? v : v + 19'h00001;
  endfunction

  function automatic logic [3:0] wrap12(input logic [3:0] a,
                                        input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, `CLP_HIST_N} - {1'b0, b};
    wrap12 = (s >= {1'b0, `CLP_HIST_N}) ? 4'(s - {1'b0, `CLP_HIST_N})
                                         : s[3:0];
  endfunction

  logic [15:0] ev_mask_reg, low_thr_reg, high_thr_reg, over_thr_reg;
  logic [18:0] start_dly_reg, max_inr_reg, min_hold_reg;
  logic [3:0]  hsel_reg, wptr_reg, hcnt_reg;
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic [2:0]  ph_low_reg, ph_high_reg, ph_over_reg;
  clp_state_t  state_reg, state_next;
  logic [18:0] start_cnt_reg, act_cnt_reg, inr_cnt_reg;
  logic [7:0]  flag_reg, flag_prv_reg;
  logic [7:0]  pend_on_reg, pend_off_reg;
  clp_ev_t     ev_reg;
  logic [31:0] rdata_reg;
  clp_rec_t    hist [12];

  // Register port decode
  wire wr_mask  = reg_wr && reg_addr == `CLP_A_EVMASK;
  wire wr_low   = reg_wr && reg_addr == `CLP_A_LOW;
  wire wr_high  = reg_wr && reg_addr == `CLP_A_HIGH;
  wire wr_over  = reg_wr && reg_addr == `CLP_A_OVER;
  wire wr_start = reg_wr && reg_addr == `CLP_A_START;
  wire wr_inr   = reg_wr && reg_addr == `CLP_A_INRUSH;
  wire wr_hold  = reg_wr && reg_addr == `CLP_A_HOLD;
  wire wr_hsel  = reg_wr && reg_addr == `CLP_A_HSEL;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ev_mask_reg   <= `CLP_DEF_MASK;
      low_thr_reg   <= `CLP_DEF_LOW;
      high_thr_reg  <= `CLP_DEF_HIGH;
      over_thr_reg  <= `CLP_DEF_OVER;
      start_dly_reg <= `CLP_DEF_START;
      max_inr_reg   <= `CLP_DEF_INRUSH;
      min_hold_reg  <= `CLP_DEF_HOLD;
      hsel_reg      <= 4'h0;
    end else begin
      if (wr_mask)  ev_mask_reg   <= reg_wdata[15:0];
      if (wr_low)   low_thr_reg   <= reg_wdata[15:0];
      if (wr_high)  high_thr_reg  <= reg_wdata[15:0];
      if (wr_over)  over_thr_reg  <= reg_wdata[15:0];
      if (wr_start) start_dly_reg <= reg_wdata[18:0];
      if (wr_inr)   max_inr_reg   <= reg_wdata[18:0];
      if (wr_hold)  min_hold_reg  <= reg_wdata[18:0];
      if (wr_hsel)  hsel_reg      <= reg_wdata[3:0];
    end
  end

  // Periodic 5 ms tick
  wire tick_wrap = tick_cnt_reg == 32'(TICK_CYC - 1);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? 32'h0 : tick_cnt_reg + 32'h1;
      tick_reg     <= tick_wrap;
    end
  end

  // Per-phase comparators with dropout hysteresis
  logic [2:0] ph_low_next, ph_high_next, ph_over_next;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ph_low_next[i]  = hyst(ph_low_reg[i], phase_current[i], low_thr_reg);
      ph_high_next[i] = hyst(ph_high_reg[i], phase_current[i], high_thr_reg);
      ph_over_next[i] = hyst(ph_over_reg[i], phase_current[i], over_thr_reg);
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_low_reg  <= 3'h0;
      ph_high_reg <= 3'h0;
      ph_over_reg <= 3'h0;
    end else begin
      ph_low_reg  <= ph_low_next;
      ph_high_reg <= ph_high_next;
      ph_over_reg <= ph_over_next;
    end
  end

  wire low_cond  = ~|ph_low_reg;
  wire high_cond = &ph_high_reg;
  wire over_cond = |ph_over_reg;
  wire norm_cond = !low_cond && !high_cond;
  wire hold_done = act_cnt_reg >= min_hold_reg;
  wire inr_done  = inr_cnt_reg >= max_inr_reg;
  wire wait_done = tick_reg && inc_sat(start_cnt_reg) >= start_dly_reg;
  wire act_st    = state_reg == ST_ACT || state_reg == ST_INR
                   || state_reg == ST_SET;
  clp_state_t  pick_st;
  assign pick_st = block_in ? ST_BLK : ST_ACT;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (low_cond)
          state_next = (start_dly_reg == 19'h0) ? pick_st : ST_WAIT;
      ST_WAIT:
        if (!low_cond) state_next = ST_IDLE;
        else if (wait_done) state_next = pick_st;
      ST_ACT:
        if (over_cond) state_next = ST_IDLE;
        else if (high_cond) state_next = ST_INR;
        else if ((!low_cond || block_in) && hold_done)
          state_next = ST_IDLE;
      ST_INR:
        if (over_cond || inr_done) state_next = ST_IDLE;
        else if (!high_cond) state_next = ST_SET;
      ST_SET:
        if (over_cond) state_next = ST_IDLE;
        else if (high_cond) state_next = ST_INR;
        else if (hold_done) state_next = ST_IDLE;
      ST_BLK:
        if (!block_in) state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Timers counted in ticks
  wire keep_inr = state_reg == ST_INR || state_reg == ST_SET;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      start_cnt_reg <= 19'h0;
      act_cnt_reg   <= 19'h0;
      inr_cnt_reg   <= 19'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_WAIT) start_cnt_reg <= 19'h0;
      else if (tick_reg) start_cnt_reg <= inc_sat(start_cnt_reg);
      if (!act_st) act_cnt_reg <= 19'h0;
      else if (tick_reg) act_cnt_reg <= inc_sat(act_cnt_reg);
      if (!keep_inr) inr_cnt_reg <= 19'h0;
      else if (tick_reg && state_reg == ST_INR)
        inr_cnt_reg <= inc_sat(inr_cnt_reg);
    end
  end

  // Flags: low, high, normal, over, active, blocked, any low, any high
  wire [7:0] flag_next = {|ph_high_reg, ~&ph_low_reg,
                          state_next == ST_BLK,
                          state_next == ST_ACT || state_next == ST_INR
                          || state_next == ST_SET,
                          over_cond, norm_cond, high_cond, low_cond};
  wire [7:0] rise = flag_reg & ~flag_prv_reg;
  wire [7:0] fall = ~flag_reg & flag_prv_reg;
  wire [15:0] pend = {pend_off_reg, pend_on_reg};
  logic [3:0] pick;
  always_comb begin
    pick = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (pend[i]) pick = 4'(i);
  end
  wire        ev_fire = |pend;
  wire [7:0]  clr_on  = (ev_fire && !pick[3]) ? 8'(1 << pick[2:0]) : 8'h0;
  wire [7:0]  clr_off = (ev_fire && pick[3]) ? 8'(1 << pick[2:0]) : 8'h0;
  wire        rec_wr  = ev_fire && !pick[3] && (pick[2:0] == `CLP_EV_ACT
                        || pick[2:0] == `CLP_EV_BLK);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_reg     <= 8'h0;
      flag_prv_reg <= 8'h0;
      pend_on_reg  <= 8'h0;
      pend_off_reg <= 8'h0;
      ev_reg       <= '0;
    end else begin
      flag_reg     <= flag_next;
      flag_prv_reg <= flag_reg;
      pend_on_reg  <= (pend_on_reg & ~clr_on)
                      | (rise & ev_mask_reg[7:0]);
      pend_off_reg <= (pend_off_reg & ~clr_off)
                      | (fall & ev_mask_reg[15:8]);
      ev_reg       <= '{valid: ev_fire, id: pick[2:0], on: !pick[3],
                        stamp: time_stamp};
    end
  end

  // Rolling history of ON records
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= 4'h0;
      hcnt_reg <= 4'h0;
    end else if (rec_wr) begin
      wptr_reg <= wrap12(wptr_reg, 4'hB);
      if (hcnt_reg != `CLP_HIST_N) hcnt_reg <= hcnt_reg + 4'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rec_wr)
      hist[wptr_reg] <= '{stamp: time_stamp, id: pick[2:0],
        group: setting_group, i1: phase_current[0],
        i2: phase_current[1], i3: phase_current[2],
        to_act: start_dly_reg - start_cnt_reg, act_time: act_cnt_reg,
        start_time: inr_cnt_reg, reclaim: act_cnt_reg};
  end

  // Read mux
  clp_rec_t rec;
  assign rec = hist[wrap12(wrap12(wptr_reg, 4'h1), hsel_reg)];
  logic [31:0] rd_val;
  always_comb begin
    case (reg_addr)
      `CLP_A_EVMASK: rd_val = {16'h0, ev_mask_reg};
      `CLP_A_LOW:    rd_val = {16'h0, low_thr_reg};
      `CLP_A_HIGH:   rd_val = {16'h0, high_thr_reg};
      `CLP_A_OVER:   rd_val = {16'h0, over_thr_reg};
      `CLP_A_START:  rd_val = {13'h0, start_dly_reg};
      `CLP_A_INRUSH: rd_val = {13'h0, max_inr_reg};
      `CLP_A_HOLD:   rd_val = {13'h0, min_hold_reg};
      `CLP_A_STATUS: rd_val = {17'h0, hcnt_reg, 3'(state_reg), flag_reg};
      `CLP_A_HSEL:   rd_val = {28'h0, hsel_reg};
      `CLP_A_RTIME:  rd_val = rec.stamp;
      `CLP_A_RID:    rd_val = {26'h0, rec.group, rec.id};
      `CLP_A_RI12:   rd_val = {rec.i2, rec.i1};
      `CLP_A_RI3:    rd_val = {16'h0, rec.i3};
      `CLP_A_RTTA:   rd_val = {13'h0, rec.to_act};
      `CLP_A_RACT:   rd_val = {13'h0, rec.act_time};
      `CLP_A_RSTART: rd_val = {13'h0, rec.start_time};
      `CLP_A_RRECL:  rd_val = {13'h0, rec.reclaim};
      default:       rd_val = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rdata_reg <= 32'h0;
    else rdata_reg <= reg_rd ? rd_val : 32'h0;
  end

  assign reg_rdata         = rdata_reg;
  assign low_start_flag    = flag_reg[0];
  assign high_start_flag   = flag_reg[1];
  assign load_normal_flag  = flag_reg[2];
  assign over_current_flag = flag_reg[3];
  assign cold_load_active  = flag_reg[4];
  assign blocked_out       = flag_reg[5];
  assign event_out         = ev_reg;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_no_early_act: assert property (state_reg == ST_WAIT && !low_cond
    |=> state_reg == ST_IDLE && !cold_load_active) else $error("early act");
  a_delay_done: assert property (state_reg == ST_WAIT && low_cond
    && wait_done && !block_in |=> $rose(cold_load_active))
    else $error("act not raised after delay");
  a_zero_delay: assert property (state_reg == ST_IDLE && low_cond
    && start_dly_reg == 19'h0 && !block_in |=> cold_load_active)
    else $error("zero delay not immediate");
  a_over_release: assert property (act_st && over_cond
    |=> !cold_load_active) else $error("overcurrent kept active");
  a_inrush_start: assert property (state_reg == ST_ACT && high_cond
    && !over_cond |=> state_reg == ST_INR) else $error("inrush not started");
  a_inrush_limit: assert property (state_reg == ST_INR && inr_done
    |=> state_reg == ST_IDLE && !cold_load_active)
    else $error("inrush exceeded maximum");
  a_hold_min: assert property (state_reg == ST_ACT && !hold_done
    && !over_cond |=> act_st) else $error("released before hold");
  a_settle_end: assert property (state_reg == ST_INR && !high_cond
    && !over_cond && !inr_done |=> state_reg == ST_SET)
    else $error("settle missed");
  a_hold_release: assert property (state_reg == ST_SET && hold_done
    && !over_cond && !high_cond |=> state_reg == ST_IDLE)
    else $error("hold release missed");
  a_block_out: assert property (state_reg == ST_IDLE && low_cond
    && start_dly_reg == 19'h0 && block_in |=> blocked_out
    && !cold_load_active) else $error("blocked output missing");
  a_tick_gap: assert property (tick_reg |=> !tick_reg)
    else $error("tick too frequent");
  a_hist_ptr: assert property (wptr_reg < `CLP_HIST_N
    && hcnt_reg <= `CLP_HIST_N) else $error("history pointer range");
  a_event_on: assert property ($rose(cold_load_active) && ev_mask_reg[4]
    |=> pend_on_reg[4] || $past(ev_fire)) else $error("on event lost");

  c_activate: cover property (state_reg == ST_WAIT ##1 state_reg == ST_ACT);
  c_inrush:   cover property (state_reg == ST_INR ##1 state_reg == ST_SET);
  c_blocked:  cover property (state_reg == ST_BLK);
  c_record:   cover property (rec_wr);

endmodule // clp_timing

/* verif/clp_current_src.sv */
`timescale 1ns/1ps
module clp_current_src (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Band per phase and fixed override
  input  wire logic [1:0]  lvl [3],
  input  wire logic        fix_en,
  input  wire logic [15:0] fix_val,
  // Measured magnitudes
  output logic      [15:0] phase_current [3]
);
  // Floor and spread of each band: low, normal, high, over
  localparam logic [15:0] BASE [4] = '{16'h0000, 16'h001E, 16'h0082,
                                       16'h00D2};
  localparam logic [15:0] SPAN [4] = '{16'h0010, 16'h0050, 16'h0040,
                                       16'h0064};

  // Fresh noisy sample every cycle, clear of the drop-out bands, or fix_val while fix_en is set
  always @(posedge ref_clk or posedge rst) begin
    for (int i = 0; i < 3; i++) begin
      if (rst)
        phase_current[i] <= 16'h0000;
      else if (fix_en)
        phase_current[i] <= fix_val;
      else
        phase_current[i] <= BASE[lvl[i]] + 16'($urandom % SPAN[lvl[i]]);
    end
  end
endmodule // clp_current_src

/* verif/tb_cold_load_pickup_timing.sv */
`timescale 1ns/1ps
`include "clp_consts.svh"
module tb_cold_load_pickup_timing;
  import clp_pkg::*;
  localparam int TICK = 10;
  localparam int S    = 3;
  localparam int H    = 4;
  localparam int M    = 6;
  localparam logic [7:0] ADRS [7] = '{`CLP_A_EVMASK, `CLP_A_LOW,
    `CLP_A_HIGH, `CLP_A_OVER, `CLP_A_START, `CLP_A_INRUSH, `CLP_A_HOLD};
  localparam logic [31:0] DEFS [7] = '{32'(`CLP_DEF_MASK),
    32'(`CLP_DEF_LOW), 32'(`CLP_DEF_HIGH), 32'(`CLP_DEF_OVER),
    32'(`CLP_DEF_START), 32'(`CLP_DEF_INRUSH), 32'(`CLP_DEF_HOLD)};
  logic        ref_clk, rst, block_in, reg_wr, reg_rd, fix_en;
  logic [2:0]  setting_group, last_sg;
  logic [31:0] time_stamp, reg_wdata, reg_rdata, d;
  logic [7:0]  reg_addr;
  logic [15:0] phase_current [3];
  logic [15:0] fix_val;
  logic [1:0]  lvl [3];
  logic        cold_load_active, blocked_out, low_start_flag;
  logic        high_start_flag, load_normal_flag, over_current_flag;
  clp_ev_t     event_out;
  int          bad_count, num_checks, n, seen_bad, on_cnt, off_cnt;
  int          ev_cnt [16];

  clp_timing #(.TICK_CYC(TICK)) dut (
    .ref_clk(ref_clk), .rst(rst), .phase_current(phase_current),
    .block_in(block_in), .setting_group(setting_group),
    .time_stamp(time_stamp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cold_load_active(cold_load_active), .blocked_out(blocked_out),
    .low_start_flag(low_start_flag), .high_start_flag(high_start_flag),
    .load_normal_flag(load_normal_flag),
    .over_current_flag(over_current_flag), .event_out(event_out));

  clp_current_src src (
    .ref_clk(ref_clk), .rst(rst), .lvl(lvl), .fix_en(fix_en),
    .fix_val(fix_val), .phase_current(phase_current));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Free-running stamp and event tally
  always @(posedge ref_clk) begin
    time_stamp <= time_stamp + 32'h1;
    if (event_out.valid === 1'b1) begin
      ev_cnt[{event_out.on, event_out.id}]++;
      chk(32'(time_stamp - event_out.stamp < 32), 32'h1, "stamp");
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s seen %0h expected %0h", $time, msg, seen,
               exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic set_all(input logic [1:0] l);
    lvl <= '{l, l, l};
  endtask

  function automatic logic outsel(input int sel);
    return sel == 0 ? cold_load_active : blocked_out;
  endfunction

  // Expected span of a timer measured in cycles
  function automatic logic [31:0] near(input int cnt, input int ticks);
    return 32'(cnt >= (ticks - 1) * TICK && cnt <= (ticks + 1) * TICK + 8);
  endfunction

  task automatic wait_out(input int sel, input logic want, input int lim);
    n = 0;
    while (outsel(sel) !== want && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= lim) begin
      $display("MISMATCH %0t output wait ran out", $time);
      bad_count++;
      close_out();
    end
  endtask

  task automatic steady(input logic want, input int cyc, input string msg);
    seen_bad = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (cold_load_active !== want)
        seen_bad++;
    end
    chk(seen_bad, 32'h0, msg);
  endtask

  task automatic activate(input int ticks);
    set_all(2'h0);
    wait_out(0, 1'b1, (ticks + 2) * TICK + 10);
  endtask

  task automatic release_all();
    set_all(2'h1);
    wait_out(0, 1'b0, (H + 3) * TICK);
  endtask

  initial begin
    void'($urandom(32'he2ed));
    rst = 1'b1;
    block_in = 1'b0;
    setting_group = 3'h0;
    time_stamp = 32'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fix_en = 1'b0;
    fix_val = 16'h0000;
    lvl = '{2'h1, 2'h1, 2'h1};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ADRS[i], d);
      chk(d, DEFS[i], "reset value");
    end
    rd(8'hFC, d);
    chk(d, 32'h0, "unmapped read");
    rd(`CLP_A_STATUS, d);
    chk(d[14:11], 32'h0, "history empty");
    wr(`CLP_A_START, S);
    wr(`CLP_A_INRUSH, M);
    wr(`CLP_A_HOLD, H);
    rd(`CLP_A_INRUSH, d);
    chk(d, M, "inrush setting");
    set_all(2'h0);
    repeat (TICK) @(posedge ref_clk);
    set_all(2'h1);
    steady(1'b0, (S + 2) * TICK, "short low");
    activate(S);
    chk(near(n, S), 32'h1, "start delay");
    set_all(2'h1);
    wait_out(0, 1'b0, (H + 3) * TICK);
    chk(near(n, H), 32'h1, "hold time");
    chk(load_normal_flag, 32'h1, "normal flag");
    activate(S);
    set_all(2'h2);
    wait_out(0, 1'b0, (M + 3) * TICK);
    chk(near(n, M), 32'h1, "inrush limit");
    chk(high_start_flag, 32'h1, "all high");
    release_all();
    activate(S);
    set_all(2'h2);
    steady(1'b1, 2 * TICK, "inrush held");
    set_all(2'h3);
    wait_out(0, 1'b0, 10);
    chk(32'(n <= 5), 32'h1, "overcurrent release");
    chk(over_current_flag, 32'h1, "over flag");
    release_all();
    activate(S);
    set_all(2'h1);
    repeat (TICK) @(posedge ref_clk);
    set_all(2'h2);
    steady(1'b1, 2 * TICK, "inrush in hold");
    release_all();
    wr(`CLP_A_START, 32'h0);
    activate(0);
    chk(32'(n <= 6), 32'h1, "zero delay");
    release_all();
    lvl <= '{2'h2, 2'h2, 2'h1};
    repeat (5) @(posedge ref_clk);
    chk(high_start_flag, 32'h0, "two high");
    lvl <= '{2'h0, 2'h0, 2'h1};
    steady(1'b0, 3 * TICK, "two low");
    chk(low_start_flag, 32'h0, "two low flag");
    fix_en <= 1'b1;
    fix_val <= 16'h001E;
    repeat (5) @(posedge ref_clk);
    fix_val <= 16'h0014;
    steady(1'b0, 3 * TICK, "hysteresis hold");
    fix_val <= 16'h0013;
    wait_out(0, 1'b1, 10);
    fix_en <= 1'b0;
    release_all();
    block_in <= 1'b1;
    set_all(2'h0);
    wait_out(1, 1'b1, 12);
    chk(cold_load_active, 32'h0, "blocked pickup");
    repeat (5) @(posedge ref_clk);
    rd(`CLP_A_RID, d);
    chk(d[2:0], `CLP_EV_BLK, "blocked record");
    set_all(2'h1);
    repeat (5) @(posedge ref_clk);
    block_in <= 1'b0;
    wait_out(1, 1'b0, 20);
    repeat (20) @(posedge ref_clk);
    for (int i = 0; i < 16; i++)
      chk(32'(ev_cnt[i] > 0), 32'h1, "event seen");
    for (int k = 0; k < 2; k++) begin
      wr(`CLP_A_EVMASK, k == 0 ? 32'h00FF : 32'hFF00);
      on_cnt = ev_cnt[12];
      off_cnt = ev_cnt[4];
      activate(0);
      release_all();
      repeat (20) @(posedge ref_clk);
      chk(ev_cnt[12] - on_cnt, 1 - k, "on stored");
      chk(ev_cnt[4] - off_cnt, k, "off stored");
    end
    wr(`CLP_A_EVMASK, 32'hFFFF);
    repeat (13) begin
      last_sg = 3'($urandom);
      setting_group <= last_sg;
      activate(0);
      repeat (TICK) @(posedge ref_clk);
      release_all();
    end
    rd(`CLP_A_STATUS, d);
    chk(d[14:11], `CLP_HIST_N, "history full");
    rd(`CLP_A_RID, d);
    chk(d[5:0], {last_sg, `CLP_EV_ACT}, "newest record");
    rd(`CLP_A_RI12, d);
    chk(32'(d[15:0] < 16'h0014), 32'h1, "record current");
    rd(`CLP_A_RTIME, d);
    chk(32'(d != 0 && d <= time_stamp), 32'h1, "record stamp");
    wr(`CLP_A_HSEL, 32'hB);
    rd(`CLP_A_RID, d);
    chk(d[2:0], `CLP_EV_ACT, "oldest record");
    close_out();
  end
endmodule // tb_cold_load_pickup_timing
